/* design/tdg_pkg.sv */
package tdg_pkg;
   // ***************************************************
   // register map
   // ***************************************************
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] COMM_OFS = 8'h08;
   localparam logic [7:0] BPCFG_OFS = 8'h0c;
   localparam logic [7:0] BPA_OFS = 8'h10;
   localparam int CTRL_DIS_BIT = 0;
   localparam int STAT_IR_LSB = 16;
   localparam int STAT_ACT_BIT = 20;
   localparam int STAT_EN_BIT = 21;
   localparam int BPCFG_FLOW_BIT = 3;
   localparam int BPCFG_STEP_BIT = 4;
   localparam logic CTRL_RST = 1'b0;
   localparam logic [4:0] BPCFG_RST = 5'h00;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ***************************************************
   // break point modes
   // ***************************************************
   localparam logic [2:0] BP_4P = 3'h0;
   localparam logic [2:0] BP_3P1D = 3'h1;
   localparam logic [2:0] BP_2P2D = 3'h2;
   localparam logic [2:0] BP_2P_PRNG = 3'h3;
   localparam logic [2:0] BP_2P_DRNG = 3'h4;
   // ***************************************************
   // scan instructions and widths
   // ***************************************************
   localparam int IR_W = 4;
   localparam int CPU_W = 16;
   localparam int ID_W = 32;
   localparam logic [3:0] IR_CAPT = 4'h1;
   localparam logic [3:0] IR_IDCODE = 4'h1;
   localparam logic [3:0] IR_BYPASS = 4'hf;
   localparam logic [3:0] IR_DBG_CPU = 4'h8;
   localparam logic [3:0] IR_DBG_COMM = 4'h9;
   localparam logic [31:0] ID_DEFAULT = 32'h0000_1001; // arbitrary code
   // ***************************************************
   // tap states
   // ***************************************************
   typedef enum logic [15:0] {
      S_TLR = 16'h0001, S_RTI = 16'h0002, S_SDR = 16'h0004,
      S_CDR = 16'h0008, S_SHDR = 16'h0010, S_E1DR = 16'h0020,
      S_PDR = 16'h0040, S_E2DR = 16'h0080, S_UDR = 16'h0100,
      S_SIR = 16'h0200, S_CIR = 16'h0400, S_SHIR = 16'h0800,
      S_E1IR = 16'h1000, S_PIR = 16'h2000, S_E2IR = 16'h4000,
      S_UIR = 16'h8000
   } tdg_state_type;
endpackage : tdg_pkg

/* design/tdg_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tdg_top #(
   parameter logic [31:0] ID_CODE = tdg_pkg::ID_DEFAULT // arbitrary value
) (
   input wire logic ref_clk, // system clock
   input wire logic reset_n, // sync reset
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // byte enables
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read valid
   input wire logic s_axi_rready, // read ready
   input wire logic tap_tck, // test clock pin
   input wire logic tap_tms, // mode-select pin
   input wire logic tap_tdi, // serial data in pin
   output logic tap_tdo_out, // serial data out
   output logic tap_tdo_oe_n, // low while driving
   output logic tap_pullup_en, // weak pull-ups on inputs
   output logic port_pin_mode, // pins act as port pins
   input wire logic test_port_enable_fuse, // fuse level
   input wire logic debug_enable_fuse, // fuse level
   input wire logic lock_bit_one, // lock level
   input wire logic lock_bit_two, // lock level
   input wire logic [15:0] cpu_pc, // program address
   input wire logic cpu_pc_valid, // fetch strobe
   input wire logic [15:0] cpu_daddr, // data address
   input wire logic cpu_dacc, // data access strobe
   input wire logic cpu_flow_change, // program flow changed
   input wire logic cpu_step_done, // one instruction done
   output logic [15:0] dbg_instr, // instruction for cpu
   output logic dbg_instr_valid, // one-cycle pulse
   output logic break_req // break to cpu
);
   // ***************************************************
   // pin synchronisers
   // ***************************************************
   logic [6:0] sy1_q, sy2_q;
   logic tck3_q;
   // two flops before any logic reads an outside level
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         sy1_q <= 7'h00;
         sy2_q <= 7'h00;
         tck3_q <= 1'b0;
      end else begin
         sy1_q <= {lock_bit_two, lock_bit_one, debug_enable_fuse,
                   test_port_enable_fuse, tap_tdi, tap_tms, tap_tck};
         sy2_q <= sy1_q;
         tck3_q <= sy2_q[0];
      end
   end
   wire tms = sy2_q[1];
   wire tdi = sy2_q[2];
   wire tck_rise = sy2_q[0] & ~tck3_q;
   wire tck_fall = ~sy2_q[0] & tck3_q;
   logic dis_q;
   wire port_en = sy2_q[3] & ~dis_q;
   wire dbg_act = port_en & sy2_q[4] & ~sy2_q[5] & ~sy2_q[6];

   // ***************************************************
   // tap state machine
   // ***************************************************
   tdg_pkg::tdg_state_type st_q, st_d;
   // next state purely from mode-select
   always_comb begin
      case (st_q)
         tdg_pkg::S_TLR: st_d = tms ? tdg_pkg::S_TLR : tdg_pkg::S_RTI;
         tdg_pkg::S_RTI: st_d = tms ? tdg_pkg::S_SDR : tdg_pkg::S_RTI;
         tdg_pkg::S_SDR: st_d = tms ? tdg_pkg::S_SIR : tdg_pkg::S_CDR;
         tdg_pkg::S_CDR: st_d = tms ? tdg_pkg::S_E1DR : tdg_pkg::S_SHDR;
         tdg_pkg::S_SHDR: st_d = tms ? tdg_pkg::S_E1DR : tdg_pkg::S_SHDR;
         tdg_pkg::S_E1DR: st_d = tms ? tdg_pkg::S_UDR : tdg_pkg::S_PDR;
         tdg_pkg::S_PDR: st_d = tms ? tdg_pkg::S_E2DR : tdg_pkg::S_PDR;
         tdg_pkg::S_E2DR: st_d = tms ? tdg_pkg::S_UDR : tdg_pkg::S_SHDR;
         tdg_pkg::S_UDR: st_d = tms ? tdg_pkg::S_SDR : tdg_pkg::S_RTI;
         tdg_pkg::S_SIR: st_d = tms ? tdg_pkg::S_TLR : tdg_pkg::S_CIR;
         tdg_pkg::S_CIR: st_d = tms ? tdg_pkg::S_E1IR : tdg_pkg::S_SHIR;
         tdg_pkg::S_SHIR: st_d = tms ? tdg_pkg::S_E1IR : tdg_pkg::S_SHIR;
         tdg_pkg::S_E1IR: st_d = tms ? tdg_pkg::S_UIR : tdg_pkg::S_PIR;
         tdg_pkg::S_PIR: st_d = tms ? tdg_pkg::S_E2IR : tdg_pkg::S_PIR;
         tdg_pkg::S_E2IR: st_d = tms ? tdg_pkg::S_UIR : tdg_pkg::S_SHIR;
         tdg_pkg::S_UIR: st_d = tms ? tdg_pkg::S_SDR : tdg_pkg::S_RTI;
         default: st_d = tdg_pkg::S_TLR;
      endcase
   end
   // no test reset pin: system reset, fuse clear or control disable bit hold only
   always_ff @(posedge ref_clk) begin
      if (!reset_n || !port_en) begin
         st_q <= tdg_pkg::S_TLR;
      end else if (tck_rise) begin
         st_q <= st_d; // five high clocks reach reset
      end
   end
   wire in_tlr = st_q == tdg_pkg::S_TLR;
   wire do_cir = tck_rise && st_q == tdg_pkg::S_CIR;
   wire do_sir = tck_rise && st_q == tdg_pkg::S_SHIR;
   wire do_uir = tck_rise && st_q == tdg_pkg::S_UIR;
   wire do_cdr = tck_rise && st_q == tdg_pkg::S_CDR;
   wire do_sdr = tck_rise && st_q == tdg_pkg::S_SHDR;
   wire do_udr = tck_rise && st_q == tdg_pkg::S_UDR;
   wire shifting = st_q == tdg_pkg::S_SHIR || st_q == tdg_pkg::S_SHDR;

   // ***************************************************
   // instruction register
   // ***************************************************
   logic [3:0] irs_q, ir_q;
   // pause and exit states touch nothing here
   always_ff @(posedge ref_clk) begin
      if (!reset_n || !port_en) begin
         irs_q <= tdg_pkg::IR_CAPT;
         ir_q <= tdg_pkg::IR_IDCODE;
      end else if (in_tlr) begin
         ir_q <= tdg_pkg::IR_IDCODE;
      end else if (do_cir) begin
         irs_q <= tdg_pkg::IR_CAPT;
      end else if (do_sir) begin
         irs_q <= {tdi, irs_q[3:1]}; // four bits, lsb first
      end else if (do_uir) begin
         ir_q <= irs_q;
      end
   end

   // ***************************************************
   // data register path select
   // ***************************************************
   wire sel_id = ir_q == tdg_pkg::IR_IDCODE;
   wire sel_cpu = dbg_act && ir_q == tdg_pkg::IR_DBG_CPU;
   wire sel_com = dbg_act && ir_q == tdg_pkg::IR_DBG_COMM;
   // anything else falls back to the single bypass stage
   wire [5:0] dr_len = sel_id ? 6'd32 : sel_cpu ? 6'd16 :
                       sel_com ? 6'd8 : 6'd1;
   logic [31:0] drs_q;
   logic [6:0] comm_q;
   logic dirty_q;
   wire [31:0] dr_cap = sel_id ? ID_CODE :
                        sel_cpu ? {16'h0000, dbg_instr} :
                        sel_com ? {24'h000000, dirty_q, comm_q} :
                        32'h00000000; // bypass cleared
   // new bit enters at the top of the selected length
   wire [31:0] dr_shift = (drs_q >> 1) |
                          ({31'h00000000, tdi} << (dr_len - 6'd1));
   // capture then shift out the captured values
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         drs_q <= 32'h00000000;
      end else if (do_cdr) begin
         drs_q <= dr_cap;
      end else if (do_sdr) begin
         drs_q <= dr_shift;
      end
   end

   // ***************************************************
   // serial output
   // ***************************************************
   // drive only while shifting, change on falling edge
   always_ff @(posedge ref_clk) begin
      if (!reset_n || !port_en) begin
         tap_tdo_out <= 1'b1;
         tap_tdo_oe_n <= 1'b1;
      end else if (tck_fall) begin
         tap_tdo_oe_n <= ~shifting;
         tap_tdo_out <= (st_q == tdg_pkg::S_SHIR) ? irs_q[0] : drs_q[0];
      end
   end
   // pins as port pins when the fuse is clear
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         tap_pullup_en <= 1'b0;
         port_pin_mode <= 1'b1;
      end else begin
         tap_pullup_en <= port_en;
         port_pin_mode <= ~sy2_q[3];
      end
   end

   // ***************************************************
   // debug instruction feed and comm register
   // ***************************************************
   // latched outputs change only in update-dr
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         dbg_instr <= 16'h0000;
         dbg_instr_valid <= 1'b0;
      end else begin
         dbg_instr_valid <= do_udr & sel_cpu;
         if (do_udr && sel_cpu) begin
            dbg_instr <= drs_q[15:0];
         end
      end
   end
   logic aw_ok_q, w_ok_q;
   logic [7:0] awa_q;
   logic [31:0] wd_q;
   logic [3:0] ws_q;
   wire wr_go = aw_ok_q & w_ok_q & ~s_axi_bvalid;
   wire wr_comm = wr_go && awa_q == tdg_pkg::COMM_OFS && ws_q[0];
   // cpu write sets, debugger update clears; set wins
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         comm_q <= 7'h00;
         dirty_q <= 1'b0;
      end else if (wr_comm) begin
         comm_q <= wd_q[6:0];
         dirty_q <= 1'b1;
      end else if (do_udr && sel_com) begin
         dirty_q <= 1'b0;
      end
   end

   // ***************************************************
   // break point unit
   // ***************************************************
   logic [4:0] bpc_q;
   logic [15:0] bpa_q [4];
   wire [2:0] mode = bpc_q[2:0];
   wire rng = mode == tdg_pkg::BP_2P_PRNG || mode == tdg_pkg::BP_2P_DRNG;
   // which slots watch data accesses in each mode
   wire [3:0] is_dat;
   assign is_dat[0] = 1'b0;
   assign is_dat[1] = 1'b0;
   assign is_dat[2] = mode == tdg_pkg::BP_2P2D ||
                      mode == tdg_pkg::BP_2P_DRNG;
   assign is_dat[3] = mode == tdg_pkg::BP_3P1D ||
                      mode == tdg_pkg::BP_2P2D;
   wire [3:0] hit;
   // slot three is the mask in range modes, so it never hits alone
   for (genvar i = 0; i < 4; i++) begin : g_bp
      wire [15:0] a = is_dat[i] ? cpu_daddr : cpu_pc;
      wire [15:0] m = (i == 2 && rng) ? ~bpa_q[3] : 16'hffff;
      wire v = is_dat[i] ? cpu_dacc : cpu_pc_valid;
      assign hit[i] = v && ((a ^ bpa_q[i]) & m) == 16'h0000 &&
                      !(i == 3 && rng);
   end
   // all break sources gated by fuses and locks
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         break_req <= 1'b0;
      end else begin
         break_req <= dbg_act & (|hit |
                      (bpc_q[tdg_pkg::BPCFG_FLOW_BIT] & cpu_flow_change) |
                      (bpc_q[tdg_pkg::BPCFG_STEP_BIT] & cpu_step_done));
      end
   end

   // ***************************************************
   // axi4-lite write channel
   // ***************************************************
   wire wa_bp = awa_q[7:4] == 4'h1 && awa_q[1:0] == 2'h0;
   wire wa_ok = awa_q == tdg_pkg::CTRL_OFS || awa_q == tdg_pkg::COMM_OFS ||
                awa_q == tdg_pkg::BPCFG_OFS || wa_bp;
   // address and data taken in either order, answer after both
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         aw_ok_q <= 1'b0;
         w_ok_q <= 1'b0;
         awa_q <= 8'h00;
         wd_q <= 32'h00000000;
         ws_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= tdg_pkg::RESP_OK;
      end else begin
         s_axi_awready <= ~aw_ok_q & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready <= ~w_ok_q & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ok_q <= 1'b1;
            awa_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ok_q <= 1'b1;
            wd_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_ok_q <= 1'b0;
            w_ok_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wa_ok ? tdg_pkg::RESP_OK : tdg_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   // control and break point registers, low byte lanes
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         dis_q <= tdg_pkg::CTRL_RST;
         bpc_q <= tdg_pkg::BPCFG_RST;
         bpa_q <= '{default: 16'h0000};
      end else if (wr_go) begin
         if (awa_q == tdg_pkg::CTRL_OFS && ws_q[0]) begin
            dis_q <= wd_q[tdg_pkg::CTRL_DIS_BIT];
         end
         if (awa_q == tdg_pkg::BPCFG_OFS && ws_q[0]) begin
            bpc_q <= wd_q[4:0];
         end
         if (wa_bp) begin
            if (ws_q[0]) bpa_q[awa_q[3:2]][7:0] <= wd_q[7:0];
            if (ws_q[1]) bpa_q[awa_q[3:2]][15:8] <= wd_q[15:8];
         end
      end
   end

   // ***************************************************
   // axi4-lite read channel
   // ***************************************************
   wire [7:0] ra = s_axi_araddr;
   wire ra_bp = ra[7:4] == 4'h1 && ra[1:0] == 2'h0;
   wire [31:0] stat = {10'h000, port_en, dbg_act, ir_q, st_q};
   wire [31:0] rd_mux = ra == tdg_pkg::CTRL_OFS ? {31'h00000000, dis_q} :
                        ra == tdg_pkg::STAT_OFS ? stat :
                        ra == tdg_pkg::COMM_OFS ?
                           {24'h000000, dirty_q, comm_q} :
                        ra == tdg_pkg::BPCFG_OFS ? {27'h0000000, bpc_q} :
                        ra_bp ? {16'h0000, bpa_q[ra[3:2]]} : 32'h00000000;
   wire ra_ok = ra == tdg_pkg::CTRL_OFS || ra == tdg_pkg::STAT_OFS ||
                ra == tdg_pkg::COMM_OFS || ra == tdg_pkg::BPCFG_OFS || ra_bp;
   // one read at a time, data held until taken
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= tdg_pkg::RESP_OK;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= ra_ok ? tdg_pkg::RESP_OK : tdg_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : tdg_top
`default_nettype wire

/* verification/tdg_props.sv */
`timescale 1ns/1ps
`default_nettype none
// port-level checks: bus handshakes, pin modes, scan output timing
module tdg_props (
   input wire logic ref_clk, // clock
   input wire logic reset_n, // sync reset
   input wire logic s_axi_awready, // aw taken
   input wire logic s_axi_arready, // ar taken
   input wire logic s_axi_bvalid, // write answer
   input wire logic s_axi_bready, // answer taken
   input wire logic [1:0] s_axi_bresp, // write code
   input wire logic tap_tck, // test clock pin
   input wire logic tap_tdo_out, // serial out
   input wire logic tap_tdo_oe_n, // low while driving
   input wire logic tap_pullup_en, // pull-ups
   input wire logic port_pin_mode, // port pin use
   input wire logic test_port_enable_fuse, // port fuse
   input wire logic debug_enable_fuse, // debug fuse
   input wire logic lock_bit_one, // lock
   input wire logic lock_bit_two, // lock
   input wire logic break_req // break out
);
   // one domain, so clock and reset are given once
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);
   property p_aw_pulse; s_axi_awready |=> !s_axi_awready; endproperty
   a_aw_pulse: assert property (p_aw_pulse) else $error("awready held two cycles");
   property p_ar_pulse; s_axi_arready |=> !s_axi_arready; endproperty
   a_ar_pulse: assert property (p_ar_pulse) else $error("arready held two cycles");
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
   property p_b_clear; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_b_clear: assert property (p_b_clear) else $error("write answer not retired");
   // sync lag of the fuse is three edges, so four low samples suffice
   property p_fuse_off; !test_port_enable_fuse [*4] |-> port_pin_mode && !tap_pullup_en && tap_tdo_oe_n; endproperty
   a_fuse_off: assert property (p_fuse_off) else $error("pins not released to port use");
   property p_tdo_fall; tap_tck [*4] |-> $stable(tap_tdo_out); endproperty
   a_tdo_fall: assert property (p_tdo_fall) else $error("data out moved while test clock high");
   property p_oe_fall; tap_tck [*4] |-> $stable(tap_tdo_oe_n); endproperty
   a_oe_fall: assert property (p_oe_fall) else $error("output enable moved while test clock high");
   property p_break_gate;
      (!debug_enable_fuse || lock_bit_one || lock_bit_two || !test_port_enable_fuse) [*6] |-> !break_req;
   endproperty
   a_break_gate: assert property (p_break_gate) else $error("break raised while debug is locked");
endmodule : tdg_props
bind tdg_top tdg_props i_tdg_props (.ref_clk, .reset_n, .s_axi_awready, .s_axi_arready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_bresp, .tap_tck, .tap_tdo_out, .tap_tdo_oe_n, .tap_pullup_en, .port_pin_mode,
   .test_port_enable_fuse, .debug_enable_fuse, .lock_bit_one, .lock_bit_two, .break_req);
`default_nettype wire

/* verification/tdg_host.sv */
`timescale 1ns/1ps
`default_nettype none
// host probe: test clock stands low between frames; no test reset pin exists to drive
module tdg_host (
   output var logic tck, // test clock
   output var logic tms, // mode select
   output var logic tdi, // data to device
   input wire logic tdo // pulled-up data out
);
   // idle levels
   initial begin
      tck = 1'h0;
      tms = 1'h1;
      tdi = 1'h1;
   end
   // one period; rise kept off the system clock phase, tdi inverted once its hold ends
   task automatic clk(input logic m, input logic d, output logic q);
      #40;
      tms <= m;
      tdi <= d;
      #43;
      q = tdo;
      tck <= 1'h1;
      #77;
      tck <= 1'h0;
      tdi <= ~d;
   endtask : clk
   // scan from run-test/idle and back, least significant bit first
   task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
      logic q;
      dout = '0;
      clk(1'h1, 1'h0, q);
      if (ir) clk(1'h1, 1'h0, q);
      clk(1'h0, 1'h0, q);
      clk(1'h0, 1'h0, q);
      for (int i = 0; i < n; i++) begin
         clk(i == n - 1, din[i], q);
         dout[i] = q;
      end
      clk(1'h1, 1'h0, q);
      clk(1'h0, 1'h0, q);
   endtask : scan
endmodule : tdg_host
`default_nettype wire

/* verification/tdg_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module tdg_bench;
   logic ref_clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, tap_tck, tap_tms, tap_tdi, tap_tdo_out;
   logic tap_tdo_oe_n, tap_pullup_en, port_pin_mode, test_port_enable_fuse, debug_enable_fuse, lock_bit_one;
   logic lock_bit_two, cpu_pc_valid, cpu_dacc, cpu_flow_change, cpu_step_done, dbg_instr_valid, break_req;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [3:0] s_axi_wstrb;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [15:0] cpu_pc, cpu_daddr, dbg_instr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   wire tdo_line;
   int err_total, checks, pulses;
   // external pull-up on the data out line
   assign tdo_line = tap_tdo_oe_n ? 1'h1 : tap_tdo_out;
   tdg_top i_tdg_top (.ref_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tap_tck,
      .tap_tms, .tap_tdi, .tap_tdo_out, .tap_tdo_oe_n, .tap_pullup_en, .port_pin_mode, .test_port_enable_fuse,
      .debug_enable_fuse, .lock_bit_one, .lock_bit_two, .cpu_pc, .cpu_pc_valid, .cpu_daddr, .cpu_dacc,
      .cpu_flow_change, .cpu_step_done, .dbg_instr, .dbg_instr_valid, .break_req);
   tdg_host i_tdg_host (.tck(tap_tck), .tms(tap_tms), .tdi(tap_tdi), .tdo(tdo_line));
   // instruction strobes from the debug chain
   always_ff @(posedge ref_clk) pulses <= pulses + dbg_instr_valid;
   // clock and watchdog
   initial begin
      ref_clk = 1'h0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      #600000;
      err_total++;
      test_done();
   end
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done
   // write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 1'h0;
      w = 1'h0;
      @(posedge ref_clk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      while (!(aw && w)) begin
         @(posedge ref_clk);
         if (s_axi_awvalid && s_axi_awready) aw = 1'h1;
         if (s_axi_wvalid && s_axi_wready) w = 1'h1;
         {s_axi_awvalid, s_axi_wvalid} <= {!aw, !w};
      end
      do @(posedge ref_clk); while (s_axi_bvalid !== 1'h1);
      chk("bresp", {30'h0, s_axi_bresp}, {30'h0, tdg_pkg::RESP_OK});
      s_axi_bready <= 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do @(posedge ref_clk); while (!(s_axi_arvalid && s_axi_arready));
      s_axi_arvalid <= 1'h0;
      while (s_axi_rvalid !== 1'h1) @(posedge ref_clk);
      {d, r} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'h0;
   endtask : rd
   // one fetch, flow, step or data strobe, then watch for the break
   task automatic hit(input logic [1:0] k, output logic seen);
      @(posedge ref_clk);
      {cpu_pc_valid, cpu_flow_change, cpu_step_done, cpu_dacc} <= {k == 2'h0, k == 2'h1, k == 2'h2, k == 2'h3};
      @(posedge ref_clk);
      {cpu_pc_valid, cpu_flow_change, cpu_step_done, cpu_dacc} <= 4'h0;
      seen = 1'h0;
      repeat (4) begin
         @(negedge ref_clk);
         seen |= break_req;
      end
   endtask : hit
   // main sequence
   initial begin
      logic [31:0] d, o, v;
      logic [1:0] r;
      logic [7:0] b;
      logic s;
      {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hf};
      {cpu_pc, cpu_daddr, cpu_pc_valid, cpu_dacc, cpu_flow_change, cpu_step_done} = 36'h0;
      {test_port_enable_fuse, debug_enable_fuse, lock_bit_one, lock_bit_two} = 4'hc;
      repeat (4) @(posedge ref_clk);
      reset_n <= 1'h1;
      void'($urandom(7));
      repeat (4) @(posedge ref_clk);
      rd(tdg_pkg::STAT_OFS, d, r);
      chk("status", d, {10'h0, 2'h3, tdg_pkg::IR_IDCODE, 16'h0001});
      rd(8'h40, d, r);
      chk("unmapped", {d[29:0], r}, {30'h0, tdg_pkg::RESP_SLVERR});
      i_tdg_host.clk(1'h0, 1'h0, s);
      i_tdg_host.scan(1'h1, 4, {28'h0, tdg_pkg::IR_BYPASS}, o);
      chk("ir capture", o, {28'h0, tdg_pkg::IR_CAPT});
      rd(tdg_pkg::STAT_OFS, d, r);
      chk("ir loaded", {28'h0, d[19:16]}, {28'h0, tdg_pkg::IR_BYPASS});
      #1;
      chk("pins", {30'h0, tap_pullup_en, port_pin_mode}, 32'h2);
      b = 8'($urandom);
      i_tdg_host.scan(1'h0, 8, {24'h0, b}, o);
      chk("bypass", o, {24'h0, b[6:0], 1'h0});
      repeat (5) i_tdg_host.clk(1'h1, 1'h0, s);
      rd(tdg_pkg::STAT_OFS, d, r);
      chk("five ones", {12'h0, d[19:0]}, {12'h0, tdg_pkg::IR_IDCODE, 16'h0001});
      i_tdg_host.clk(1'h0, 1'h0, s);
      i_tdg_host.scan(1'h0, 32, $urandom, o);
      chk("idcode", o, tdg_pkg::ID_DEFAULT);
      $display("test scan paths done");
      b = 8'($urandom);
      wr(tdg_pkg::COMM_OFS, {25'h0, b[6:0]});
      rd(tdg_pkg::COMM_OFS, d, r);
      chk("dirty set", d, {24'h0, 1'h1, b[6:0]});
      i_tdg_host.scan(1'h1, 4, {28'h0, tdg_pkg::IR_DBG_COMM}, o);
      i_tdg_host.scan(1'h0, 8, $urandom, o);
      chk("comm scan", o, {24'h0, 1'h1, b[6:0]});
      rd(tdg_pkg::COMM_OFS, d, r);
      chk("dirty cleared", d, {24'h0, 1'h0, b[6:0]});
      v = $urandom;
      i_tdg_host.scan(1'h1, 4, {28'h0, tdg_pkg::IR_DBG_CPU}, o);
      i_tdg_host.scan(1'h0, 16, v, o);
      chk("cpu instr", {16'h0, dbg_instr}, {16'h0, v[15:0]});
      chk("instr strobe", pulses, 32'h1);
      $display("test debug chains done");
      wr(tdg_pkg::BPA_OFS, v);
      @(posedge ref_clk);
      {cpu_pc, lock_bit_one} <= {v[15:0], 1'h1};
      rd(tdg_pkg::STAT_OFS, d, r);
      chk("locked", {31'h0, d[20]}, 32'h0);
      hit(2'h0, s);
      chk("locked break", {31'h0, s}, 32'h0);
      lock_bit_one <= 1'h0;
      repeat (4) @(posedge ref_clk);
      for (int m = 0; m < 5; m++) begin
         wr(tdg_pkg::BPCFG_OFS, {29'h0, m[2:0]});
         hit(2'h0, s);
         chk("pc break", {31'h0, s}, 32'h1);
      end
      wr(tdg_pkg::BPCFG_OFS, 32'h8);
      cpu_pc <= ~v[15:0];
      hit(2'h1, s);
      chk("flow break", {31'h0, s}, 32'h1);
      wr(tdg_pkg::BPA_OFS + 8'h0c, ~v);
      wr(tdg_pkg::BPCFG_OFS, 32'h11);
      cpu_daddr <= ~v[15:0];
      for (int k = 2; k < 4; k++) begin
         hit(k[1:0], s);
         chk("step or data break", {31'h0, s}, 32'h1);
      end
      @(posedge ref_clk);
      lock_bit_two <= 1'h1;
      repeat (4) @(posedge ref_clk);
      hit(2'h2, s);
      chk("lock two", {31'h0, s}, 32'h0);
      $display("test break unit done");
      @(posedge ref_clk);
      reset_n <= 1'h0; // debugger pulls the system reset line
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'h1;
      repeat (4) @(posedge ref_clk);
      rd(tdg_pkg::STAT_OFS, d, r);
      chk("reset again", d, {10'h0, 2'h2, tdg_pkg::IR_IDCODE, 16'h0001});
      wr(tdg_pkg::CTRL_OFS, 32'h1);
      rd(tdg_pkg::STAT_OFS, d, r);
      #1;
      chk("disabled", {30'h0, d[21], tap_pullup_en}, 32'h0);
      i_tdg_host.scan(1'h1, 4, 32'h0, o);
      chk("tdo floats", o, 32'hf);
      @(posedge ref_clk);
      test_port_enable_fuse <= 1'h0;
      repeat (5) @(negedge ref_clk);
      chk("port pins", {31'h0, port_pin_mode}, 32'h1);
      $display("test port enable done");
      test_done();
   end
endmodule : tdg_bench
`default_nettype wire
